// file: hdl/mssb_pkg.sv
// Function
// - Low mode 0 holds output at lower limit.
// - Low mode 1 decelerates to stop instead.
// - Stop decel starts braking at brake frequency.
// - Zero brake time disables stop braking.
// - Brake start frequency limited 0.0 to 60.0.
// - Brake level in 1 percent, max 80.
// - Stop braking lasts brake time, up to 30.
// - Response 0 ramps current slowly, 1 quickly.
// - Forced brake input brakes, ignoring brake time.
// - Forced brake also works while stopped.
// - Run first applies startup braking for its time.
// - Start at starting frequency, never below 0.1; the code applies this floor only with CTRL_VF set.
// - Hold starting frequency for hold time.
// - Output stops at stop frequency, minimum 0.1; the code applies this floor only with CTRL_VF set.
// - Start below stop waits for reference above stop.
// - Upper clamps output, lower clamps reference.
package mssb_pkg;
  localparam int FREQ_W = 11;
  localparam int TIME_W = 12;
  localparam int LVL_W = 7;
  // Byte addresses of the registers.
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_UPPER = 6'h04;
  localparam logic [5:0] ADDR_LOWER = 6'h08;
  localparam logic [5:0] ADDR_MAXF = 6'h0C;
  localparam logic [5:0] ADDR_REF = 6'h10;
  localparam logic [5:0] ADDR_BSF = 6'h14;
  localparam logic [5:0] ADDR_BLVL = 6'h18;
  localparam logic [5:0] ADDR_BDUR = 6'h1C;
  localparam logic [5:0] ADDR_SBDUR = 6'h20;
  localparam logic [5:0] ADDR_START = 6'h24;
  localparam logic [5:0] ADDR_HOLD = 6'h28;
  localparam logic [5:0] ADDR_STOP = 6'h2C;
  localparam logic [5:0] ADDR_STEP = 6'h30;
  localparam logic [5:0] ADDR_STATUS = 6'h34;
  // Control register bit positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_LOWMODE = 1;
  localparam int CTRL_RESP = 2;
  localparam int CTRL_VF = 3;
  // Status register field positions.
  localparam int STAT_FREQ_LSB = 0;
  localparam int STAT_LVL_LSB = 16;
  localparam int STAT_STATE_LSB = 24;
  // Setting limits in 0.1 Hz, 1 percent and 0.01 s units.
  localparam logic [11:0] FREQ_MAX_60 = 12'h258;
  localparam logic [11:0] FREQ_MAX_120 = 12'h4B0;
  localparam logic [11:0] LVL_MAX = 12'h050;
  localparam logic [11:0] TIME_MAX_30 = 12'hBB8;
  localparam logic [11:0] TIME_MAX_10 = 12'h3E8;
  localparam logic [FREQ_W-1:0] FREQ_FLOOR = 11'h001;
  // Values after reset.
  localparam logic [3:0] RST_CTRL = 4'h8;
  localparam logic [FREQ_W-1:0] RST_UPPER = 11'h258;
  localparam logic [FREQ_W-1:0] RST_LOWER = 11'h000;
  localparam logic [FREQ_W-1:0] RST_MAXF = 11'h258;
  localparam logic [FREQ_W-1:0] RST_REF = 11'h000;
  localparam logic [FREQ_W-1:0] RST_BSF = 11'h000;
  localparam logic [LVL_W-1:0] RST_BLVL = 7'h00;
  localparam logic [TIME_W-1:0] RST_BDUR = 12'h000;
  localparam logic [TIME_W-1:0] RST_SBDUR = 12'h000;
  localparam logic [FREQ_W-1:0] RST_START = 11'h005;
  localparam logic [TIME_W-1:0] RST_HOLD = 12'h000;
  localparam logic [FREQ_W-1:0] RST_STOP = 11'h002;
  localparam logic [FREQ_W-1:0] RST_STEP = 11'h001;
  // Timer tick of 10 ms at the 50 MHz clock.
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SBRAKE = 6'h02,
    ST_HOLD = 6'h04,
    ST_RUN = 6'h08,
    ST_DECEL = 6'h10,
    ST_BRAKE = 6'h20
  } mssb_state_t;
endpackage : mssb_pkg

// file: hdl/mssb_seq.sv
`timescale 1ns/10ps
module mssb_seq #(
  parameter int TICK_CYC = mssb_pkg::TICK_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // External forced braking pin.
  input wire logic forced_brake_input,
  // Drive outputs.
  output logic [mssb_pkg::FREQ_W-1:0] out_freq,
  output logic output_on,
  output logic brake_on,
  output logic [mssb_pkg::LVL_W-1:0] brake_level
);
  localparam int FW = mssb_pkg::FREQ_W;
  localparam int TW = mssb_pkg::TIME_W;
  localparam int LW = mssb_pkg::LVL_W;

  logic [3:0] ctrl_q;
  logic [FW-1:0] upper_freq_limit_q, lower_freq_limit_q, maximum_freq_q, ref_freq_q;
  logic [FW-1:0] brake_start_freq_q, start_freq_q, stop_freq_q, ramp_step_q;
  logic [LW-1:0] brake_current_level_q;
  logic [TW-1:0] brake_duration_q, startup_brake_duration_q, start_freq_hold_time_q;
  logic ack_q;
  logic [31:0] readdata_q, rd_word, wr_word, be_mask;
  logic [19:0] tick_cnt_q;
  logic tick;
  logic sync1_q, sync2_q, sync3_q, forced_q;
  mssb_pkg::mssb_state_t state_q;
  logic [TW-1:0] timer_q;
  logic [FW-1:0] out_freq_q;
  logic [LW-1:0] brake_level_q;
  logic [FW-1:0] eff_start, eff_stop, ref_lim, tgt;
  logic low_stop, run_ok, brk_cond, cut_cond, brake_w;

  function automatic logic [11:0] clamp_to(input logic [31:0] v, input logic [11:0] hi);
    clamp_to = (v > {20'h00000, hi}) ? hi : v[11:0];
  endfunction : clamp_to

  // Bus handshake: every access is answered one cycle after it is presented.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = readdata_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    case (avs_address)
      mssb_pkg::ADDR_CTRL: rd_word = {28'h0000000, ctrl_q};
      mssb_pkg::ADDR_UPPER: rd_word = {21'h000000, upper_freq_limit_q};
      mssb_pkg::ADDR_LOWER: rd_word = {21'h000000, lower_freq_limit_q};
      mssb_pkg::ADDR_MAXF: rd_word = {21'h000000, maximum_freq_q};
      mssb_pkg::ADDR_REF: rd_word = {21'h000000, ref_freq_q};
      mssb_pkg::ADDR_BSF: rd_word = {21'h000000, brake_start_freq_q};
      mssb_pkg::ADDR_BLVL: rd_word = {25'h0000000, brake_current_level_q};
      mssb_pkg::ADDR_BDUR: rd_word = {20'h00000, brake_duration_q};
      mssb_pkg::ADDR_SBDUR: rd_word = {20'h00000, startup_brake_duration_q};
      mssb_pkg::ADDR_START: rd_word = {21'h000000, start_freq_q};
      mssb_pkg::ADDR_HOLD: rd_word = {20'h00000, start_freq_hold_time_q};
      mssb_pkg::ADDR_STOP: rd_word = {21'h000000, stop_freq_q};
      mssb_pkg::ADDR_STEP: rd_word = {21'h000000, ramp_step_q};
      mssb_pkg::ADDR_STATUS: begin
        rd_word[mssb_pkg::STAT_FREQ_LSB +: FW] = out_freq_q;
        rd_word[mssb_pkg::STAT_LVL_LSB +: LW] = brake_level_q;
        rd_word[mssb_pkg::STAT_STATE_LSB +: 6] = state_q;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // Byte enables merge new data into the current register value.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    wr_word = (rd_word & ~be_mask) | (avs_writedata & be_mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_q <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      readdata_q <= rd_word;
    end
  end

  // Register writes take effect at the edge where waitrequest is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= mssb_pkg::RST_CTRL;
      upper_freq_limit_q <= mssb_pkg::RST_UPPER;
      lower_freq_limit_q <= mssb_pkg::RST_LOWER;
      maximum_freq_q <= mssb_pkg::RST_MAXF;
      ref_freq_q <= mssb_pkg::RST_REF;
      brake_start_freq_q <= mssb_pkg::RST_BSF;
      brake_current_level_q <= mssb_pkg::RST_BLVL;
      brake_duration_q <= mssb_pkg::RST_BDUR;
      startup_brake_duration_q <= mssb_pkg::RST_SBDUR;
      start_freq_q <= mssb_pkg::RST_START;
      start_freq_hold_time_q <= mssb_pkg::RST_HOLD;
      stop_freq_q <= mssb_pkg::RST_STOP;
      ramp_step_q <= mssb_pkg::RST_STEP;
    end else if (avs_write && ack_q) begin
      case (avs_address)
        mssb_pkg::ADDR_CTRL: ctrl_q <= wr_word[3:0];
        mssb_pkg::ADDR_UPPER: upper_freq_limit_q <=
          FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_120));
        mssb_pkg::ADDR_LOWER: lower_freq_limit_q <=
          FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_120));
        mssb_pkg::ADDR_MAXF: maximum_freq_q <= FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_120));
        mssb_pkg::ADDR_REF: ref_freq_q <= FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_120));
        mssb_pkg::ADDR_BSF: brake_start_freq_q <=
          FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_60));
        mssb_pkg::ADDR_BLVL: brake_current_level_q <=
          LW'(clamp_to(wr_word, mssb_pkg::LVL_MAX));
        mssb_pkg::ADDR_BDUR: brake_duration_q <= clamp_to(wr_word, mssb_pkg::TIME_MAX_30);
        mssb_pkg::ADDR_SBDUR: startup_brake_duration_q <=
          clamp_to(wr_word, mssb_pkg::TIME_MAX_30);
        mssb_pkg::ADDR_START: start_freq_q <=
          FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_60));
        mssb_pkg::ADDR_HOLD: start_freq_hold_time_q <=
          clamp_to(wr_word, mssb_pkg::TIME_MAX_10);
        mssb_pkg::ADDR_STOP: stop_freq_q <=
          FW'(clamp_to(wr_word, mssb_pkg::FREQ_MAX_60));
        mssb_pkg::ADDR_STEP: ramp_step_q <= wr_word[FW-1:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // The 10 ms tick that paces timers and ramps.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 20'h00000;
    end else if (tick) begin
      tick_cnt_q <= 20'h00000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 20'h00001;
    end
  end
  assign tick = (tick_cnt_q == 20'(TICK_CYC - 1));

  // The pin passes three flip-flops; a change counts when the last two agree.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      forced_q <= 1'b0;
    end else begin
      sync1_q <= forced_brake_input;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        forced_q <= sync3_q;
      end
    end
  end

  // Effective frequencies, limits and start or stop conditions.
  always_comb begin
    eff_start = start_freq_q;
    eff_stop = stop_freq_q;
    if (ctrl_q[mssb_pkg::CTRL_VF] && start_freq_q == '0) begin
      eff_start = mssb_pkg::FREQ_FLOOR;
    end
    if (ctrl_q[mssb_pkg::CTRL_VF] && stop_freq_q == '0) begin
      eff_stop = mssb_pkg::FREQ_FLOOR;
    end
    low_stop = ctrl_q[mssb_pkg::CTRL_LOWMODE] && (ref_freq_q < lower_freq_limit_q);
    ref_lim = (ref_freq_q < lower_freq_limit_q) ? lower_freq_limit_q : ref_freq_q;
    tgt = ref_lim;
    if (tgt > upper_freq_limit_q) begin
      tgt = upper_freq_limit_q;
    end
    if (tgt > maximum_freq_q) begin
      tgt = maximum_freq_q;
    end
    run_ok = ctrl_q[mssb_pkg::CTRL_RUN] && (ref_freq_q > eff_stop) && !low_stop;
    brk_cond = (brake_duration_q != '0) && (out_freq_q <= brake_start_freq_q);
    cut_cond = (out_freq_q <= eff_stop);
  end

  // Sequencer: startup brake, hold, run, decelerate, then brake or cutoff.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= mssb_pkg::ST_IDLE;
      timer_q <= '0;
      out_freq_q <= '0;
    end else if (forced_q) begin
      state_q <= mssb_pkg::ST_BRAKE;
      timer_q <= '0;
      out_freq_q <= '0;
    end else begin
      if (tick && timer_q != '0) begin
        timer_q <= timer_q - 12'h001;
      end
      case (state_q)
        mssb_pkg::ST_IDLE: begin
          out_freq_q <= '0;
          if (run_ok && startup_brake_duration_q != '0) begin
            state_q <= mssb_pkg::ST_SBRAKE;
            timer_q <= startup_brake_duration_q;
          end else if (run_ok) begin
            state_q <= mssb_pkg::ST_HOLD;
            timer_q <= start_freq_hold_time_q;
            out_freq_q <= eff_start;
          end
        end
        mssb_pkg::ST_SBRAKE: begin
          if (timer_q == '0) begin
            state_q <= mssb_pkg::ST_HOLD;
            timer_q <= start_freq_hold_time_q;
            out_freq_q <= eff_start;
          end
        end
        mssb_pkg::ST_HOLD: begin
          if (!run_ok) begin
            state_q <= mssb_pkg::ST_DECEL;
          end else if (timer_q == '0) begin
            state_q <= mssb_pkg::ST_RUN;
          end
        end
        mssb_pkg::ST_RUN: begin
          if (!run_ok) begin
            state_q <= mssb_pkg::ST_DECEL;
          end else if (tick && out_freq_q < tgt) begin
            out_freq_q <= (tgt - out_freq_q > ramp_step_q) ? out_freq_q + ramp_step_q : tgt;
          end else if (tick && out_freq_q > tgt) begin
            out_freq_q <= (out_freq_q - tgt > ramp_step_q) ? out_freq_q - ramp_step_q : tgt;
          end
        end
        mssb_pkg::ST_DECEL: begin
          if (run_ok) begin
            state_q <= mssb_pkg::ST_RUN;
          end else if (brk_cond) begin
            state_q <= mssb_pkg::ST_BRAKE;
            timer_q <= brake_duration_q;
            out_freq_q <= '0;
          end else if (cut_cond) begin
            state_q <= mssb_pkg::ST_IDLE;
            out_freq_q <= '0;
          end else if (tick) begin
            out_freq_q <= (out_freq_q > ramp_step_q) ? out_freq_q - ramp_step_q : '0;
          end
        end
        mssb_pkg::ST_BRAKE: begin
          if (timer_q == '0) begin
            state_q <= mssb_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= mssb_pkg::ST_IDLE;
          out_freq_q <= '0;
        end
      endcase
    end
  end

  assign brake_w = (state_q == mssb_pkg::ST_SBRAKE) || (state_q == mssb_pkg::ST_BRAKE);

  // Braking current: quick mode jumps, slow mode climbs one percent per tick.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brake_level_q <= '0;
    end else if (!brake_w) begin
      brake_level_q <= '0;
    end else if (ctrl_q[mssb_pkg::CTRL_RESP]) begin
      brake_level_q <= brake_current_level_q;
    end else if (tick && brake_level_q < brake_current_level_q) begin
      brake_level_q <= brake_level_q + 7'h01;
    end else if (brake_level_q > brake_current_level_q) begin
      brake_level_q <= brake_current_level_q;
    end
  end

  assign out_freq = out_freq_q;
  assign output_on = (state_q == mssb_pkg::ST_HOLD) || (state_q == mssb_pkg::ST_RUN) ||
                     (state_q == mssb_pkg::ST_DECEL);
  assign brake_on = brake_w;
  assign brake_level = brake_level_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_enter_hold;
    (state_q == mssb_pkg::ST_IDLE) ##1 (state_q == mssb_pkg::ST_HOLD);
  endsequence
  sequence s_forced_stable;
    forced_q [*2];
  endsequence

  property p_forced_brake;
    s_forced_stable |-> (state_q == mssb_pkg::ST_BRAKE) && brake_on && !output_on;
  endproperty
  a_forced_brake: assert property (p_forced_brake) else $error("forced brake not held");
  property p_idle_forced;
    (state_q == mssb_pkg::ST_IDLE) && forced_q |=> brake_on ##1 brake_on;
  endproperty
  a_idle_forced: assert property (p_idle_forced) else $error("no braking when stopped");
  property p_zero_duration;
    (state_q == mssb_pkg::ST_DECEL) && (brake_duration_q == '0) && !forced_q
      |=> state_q != mssb_pkg::ST_BRAKE;
  endproperty
  a_zero_duration: assert property (p_zero_duration) else $error("brake with zero time");
  property p_level_max;
    brake_level_q <= 7'h50 && brake_current_level_q <= 7'h50;
  endproperty
  a_level_max: assert property (p_level_max) else $error("brake level above 80");
  property p_quick;
    brake_w && ctrl_q[mssb_pkg::CTRL_RESP] && !forced_q
      ##1 brake_w && $stable(brake_current_level_q) |-> brake_level_q == brake_current_level_q;
  endproperty
  a_quick: assert property (p_quick) else $error("quick response level late");
  property p_slow;
    brake_w && !ctrl_q[mssb_pkg::CTRL_RESP] && !tick ##1 brake_w
      |-> brake_level_q <= $past(brake_level_q);
  endproperty
  a_slow: assert property (p_slow) else $error("slow response rose without tick");
  property p_start_freq;
    s_enter_hold |-> out_freq_q == $past(eff_start)
      && (out_freq_q != '0 || !$past(ctrl_q[mssb_pkg::CTRL_VF]));
  endproperty
  a_start_freq: assert property (p_start_freq) else $error("wrong starting frequency");
  property p_startup_brake;
    (state_q == mssb_pkg::ST_IDLE) && run_ok && !forced_q && (startup_brake_duration_q != '0)
      |=> (state_q == mssb_pkg::ST_SBRAKE) && !output_on;
  endproperty
  a_startup_brake: assert property (p_startup_brake) else $error("startup brake skipped");
  property p_no_start;
    (state_q == mssb_pkg::ST_IDLE) && !run_ok && !forced_q |=> state_q == mssb_pkg::ST_IDLE;
  endproperty
  a_no_start: assert property (p_no_start) else $error("started without reference");
  property p_cutoff;
    (state_q == mssb_pkg::ST_DECEL) && !run_ok && !brk_cond && cut_cond && !forced_q
      |=> !output_on && out_freq_q == '0;
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("output not cut at stop freq");
  property p_ramp_bound;
    (state_q == mssb_pkg::ST_RUN) && run_ok && tick && !forced_q
      |=> out_freq_q <= $past(upper_freq_limit_q) || out_freq_q < $past(out_freq_q);
  endproperty
  a_ramp_bound: assert property (p_ramp_bound) else $error("output above upper limit");
  property p_brake_entry;
    (state_q == mssb_pkg::ST_DECEL) && !run_ok && brk_cond && !forced_q
      |=> (state_q == mssb_pkg::ST_BRAKE) && timer_q == $past(brake_duration_q);
  endproperty
  a_brake_entry: assert property (p_brake_entry) else $error("stop braking not started");
endmodule : mssb_seq

// file: test/mssb_motor.sv
`timescale 1ns/10ps
module mssb_motor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Drive side of the power stage.
  input wire logic [mssb_pkg::FREQ_W-1:0] out_freq,
  input wire logic output_on,
  input wire logic brake_on,
  input wire logic [mssb_pkg::LVL_W-1:0] brake_level,
  // Shaft speed in 0.1 Hz.
  output logic [mssb_pkg::FREQ_W-1:0] speed_q
);
  logic [mssb_pkg::FREQ_W-1:0] speed_d;
  // The shaft follows the drive, is pulled down by braking current and coasts otherwise.
  always_comb begin
    if (output_on) begin
      speed_d = out_freq;
    end else if (brake_on) begin
      speed_d = (speed_q > {4'h0, brake_level}) ? speed_q - {4'h0, brake_level} : '0;
    end else begin
      speed_d = (speed_q != '0) ? speed_q - 11'h001 : '0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_q <= '0;
    end else begin
      speed_q <= speed_d;
    end
  end
endmodule : mssb_motor

// file: test/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic forced_brake_input = 1'b0;
  logic [mssb_pkg::FREQ_W-1:0] out_freq;
  logic [mssb_pkg::FREQ_W-1:0] last_f = 11'h000;
  logic [mssb_pkg::FREQ_W-1:0] speed;
  logic output_on;
  logic brake_on;
  logic [mssb_pkg::LVL_W-1:0] brake_level;
  logic [31:0] rdat;
  logic [31:0] rst_tab [15] = '{32'h8, 32'h258, 32'h0, 32'h258, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h5, 32'h0, 32'h2, 32'h1, 32'h1000000, 32'h0};
  logic [11:0] max_tab [11] = '{12'h4B0, 12'h4B0, 12'h0, 12'h0, 12'h258, 12'h050, 12'hBB8,
    12'hBB8, 12'h258, 12'h3E8, 12'h258};
  int n_fail = 0;
  int tests_run = 0;
  int cyc;
  int brk_cnt = 0;
  int brk_mark;
  always #10 clk = ~clk;
  always @(posedge clk) if (output_on) last_f <= out_freq;
  always @(negedge clk) brk_cnt <= brk_cnt + int'(brake_on);
  mssb_seq #(.TICK_CYC(TK)) dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .forced_brake_input(forced_brake_input), .out_freq(out_freq), .output_on(output_on),
    .brake_on(brake_on), .brake_level(brake_level)
  );
  mssb_motor motor (.clk(clk), .rst_b(rst_b), .out_freq(out_freq), .output_on(output_on),
    .brake_on(brake_on), .brake_level(brake_level), .speed_q(speed));
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // One bus cycle; the answer is taken at the rising edge where waitrequest is low.
  task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic cfg(input logic [11:0] v [11]);
    for (int i = 0; i < 11; i++) begin
      wr(6'h04 + 6'(4 * i), {20'h00000, v[i]});
    end
  endtask : cfg
  task automatic wt(input bit brk, input logic lv, input int lim);
    cyc = 0;
    while ((brk ? brake_on : output_on) !== lv && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
  endtask : wt
  task automatic halt();
    wr(6'h00, 32'h8);
    wt(1'b0, 1'b0, 500);
    wt(1'b1, 1'b0, 500);
  endtask : halt
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      rd(6'(4 * i));
      `CHK("reset value", rst_tab[i], rdat)
    end
    for (int i = 0; i < 11; i++) begin
      wr(6'h04 + 6'(4 * i), 32'h0000FFFF);
      rd(6'h04 + 6'(4 * i));
      if (i != 2 && i != 3) `CHK("clamp", {20'h0, max_tab[i]}, rdat)
    end
    cfg('{12'h258, 12'h0, 12'h258, 12'h32, 12'h0, 12'h28, 12'h0, 12'h3, 12'h0, 12'h3,
      12'h2});
    wr(6'h00, 32'h9);
    wt(1'b1, 1'b1, 40);
    `CHK("brake before drive", 1'b0, output_on)
    wt(1'b1, 1'b0, 40);
    `CHK("startup brake time", 1'b1, cyc >= 2 * TK && cyc <= 4 * TK + 4)
    wt(1'b0, 1'b1, 8);
    `CHK("start freq floor", 11'h001, out_freq)
    cyc = 0;
    while (out_freq === 11'h001 && cyc < 100) begin
      @(negedge clk);
      cyc++;
    end
    `CHK("hold time", 1'b1, cyc >= 2 * TK && cyc <= 5 * TK + 4)
    halt();
    cfg('{12'h28, 12'h0, 12'h258, 12'h64, 12'h0, 12'h0, 12'h0, 12'h0, 12'h5, 12'h0,
      12'h2});
    wr(6'h00, 32'h9);
    repeat (250) @(negedge clk);
    `CHK("upper clamp", 11'h028, out_freq)
    wr(6'h08, 32'h1E);
    wr(6'h10, 32'hA);
    repeat (100) @(negedge clk);
    `CHK("lower hold", 11'h01E, out_freq)
    wr(6'h00, 32'hB);
    wt(1'b0, 1'b0, 400);
    `CHK("decel to stop", 1'b1, cyc >= 24 * TK && cyc <= 30 * TK + 8)
    wr(6'h00, 32'h8);
    cfg('{12'h258, 12'h0, 12'h258, 12'h1E, 12'hF, 12'h28, 12'h5, 12'h0, 12'h5, 12'h0,
      12'h2});
    wr(6'h00, 32'hD);
    repeat (150) @(negedge clk);
    wr(6'h00, 32'hC);
    wt(1'b1, 1'b1, 300);
    `CHK("brake start freq", 11'h00F, last_f)
    repeat (2) @(negedge clk);
    `CHK("quick level", 7'h28, brake_level)
    wt(1'b1, 1'b0, 80);
    `CHK("brake time", 1'b1, cyc >= 3 * TK && cyc <= 6 * TK + 4)
    `CHK("shaft stopped", 11'h000, speed)
    wr(6'h00, 32'h9);
    repeat (150) @(negedge clk);
    wr(6'h00, 32'h8);
    wt(1'b1, 1'b1, 300);
    repeat (2) @(negedge clk);
    `CHK("slow level", 1'b1, brake_level <= 7'h02)
    halt();
    wr(6'h1C, 32'h0);
    wr(6'h2C, 32'h0);
    wr(6'h00, 32'h9);
    repeat (150) @(negedge clk);
    brk_mark = brk_cnt;
    halt();
    `CHK("no stop brake", brk_mark, brk_cnt)
    `CHK("stop freq floor", 11'h001, last_f)
    cfg('{12'h258, 12'h0, 12'h258, 12'h1E, 12'h0, 12'h0, 12'h0, 12'h0, 12'hA, 12'h0,
      12'h28});
    wr(6'h00, 32'h9);
    repeat (100) @(negedge clk);
    `CHK("no output below stop", 1'b0, output_on)
    wr(6'h10, 32'h32);
    wt(1'b0, 1'b1, 20);
    `CHK("output above stop", 1'b1, output_on)
    halt();
    wr(6'h1C, 32'h2);
    @(posedge clk);
    forced_brake_input <= 1'b1;
    wt(1'b1, 1'b1, 10);
    `CHK("forced from idle", 1'b1, brake_on)
    repeat (60) @(negedge clk);
    `CHK("forced holds", 1'b1, brake_on)
    @(posedge clk);
    forced_brake_input <= 1'b0;
    wt(1'b1, 1'b0, 10);
    `CHK("forced release", 1'b0, brake_on)
    close_out();
  end
endmodule : tb_top
